/* File: common/ocd_pkg.sv */
package ocd_pkg;
   // ==========================================================
   // Register offsets.
   localparam logic [6:0] ADDR_RSVD_A = 7'h43;
   localparam logic [6:0] ADDR_OC_STATUS = 7'h45;
   localparam logic [6:0] ADDR_HP_PROT = 7'h4d;
   localparam logic [6:0] ADDR_RSVD_B = 7'h4e;
   localparam logic [6:0] ADDR_TUNE_ONE = 7'h77;
   // ==========================================================
   // Field positions.
   localparam int OC_RCV_BIT = 7;
   localparam int OC_HP_BIT = 6;
   localparam int OC_SPK_BIT = 5;
   localparam int PROT_EN_BIT = 0;
   localparam int PERIOD_MSB = 7;
   localparam int PERIOD_LSB = 6;
   localparam int HIGH_MSB = 5;
   localparam int HIGH_LSB = 2;
   localparam int SCALE_BIT = 1;
   localparam int AUTO_BIT = 0;
   // ==========================================================
   // Reset values and field codes.
   localparam logic [7:0] RST_HP_PROT = 8'h00;
   localparam logic [7:0] RST_TUNE_ONE = 8'h94;
   localparam logic [7:0] RSVD_VALUE = 8'h00;
   localparam logic [1:0] PERIOD_OFF = 2'h0;
   localparam logic [1:0] PERIOD_SHORT = 2'h1;
   localparam logic [1:0] PERIOD_MID = 2'h2;
   localparam logic [1:0] PERIOD_LONG = 2'h3;
   // ==========================================================
   // Timing in low-frequency oscillator cycles.
   localparam int CYC_PERIOD_SHORT = 144;
   localparam int CYC_PERIOD_MID = 288;
   localparam int CYC_PERIOD_LONG = 4608;
   localparam int SCALE_LOW = 1;
   localparam int SCALE_HIGH = 8;
   // ==========================================================
   // Serial frame layout.
   localparam int FRAME_BITS = 16;
   localparam int HEAD_BITS = 8;
   // ==========================================================
   // Pulse generator states.
   typedef enum logic [2:0] {
      PG_IDLE = 3'b001,
      PG_HIGH = 3'b010,
      PG_LOW = 3'b100
   } ocd_pulse_state_type;
endpackage

/* File: src/ocd_serial_port.sv */
`timescale 1ns/1ns
module ocd_serial_port (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Serial pins.
   input wire logic sclk_in,
   input wire logic ss_n_in,
   input wire logic mosi_in,
   output logic miso_out,
   // Register side.
   output logic [6:0] addr_out,
   output logic wr_out,
   output logic [7:0] wdata_out,
   input wire logic [7:0] rdata_in
);
   logic sclk_q, sclk_d;
   logic [15:0] rx_q, rx_d;
   logic [4:0] cnt_q, cnt_d;
   logic [7:0] tx_q, tx_d;
   logic miso_q, miso_d;
   logic wr_q, wr_d;
   logic rise, fall;

   localparam int HEAD_BITS_ADDR_MSB = ocd_pkg::HEAD_BITS - 1;
   localparam int FRAME_ADDR_LSB = ocd_pkg::FRAME_BITS - ocd_pkg::HEAD_BITS + 1;

   assign rise = sclk_in & ~sclk_q;
   assign fall = ~sclk_in & sclk_q;
   // Mid-frame the header fills the low byte; a full frame has pushed it to the top.
   assign addr_out = (cnt_q == 5'(ocd_pkg::FRAME_BITS)) ? rx_q[15:FRAME_ADDR_LSB]
      : rx_q[HEAD_BITS_ADDR_MSB:1];
   assign wdata_out = rx_q[7:0];
   assign wr_out = wr_q;
   assign miso_out = miso_q;

   always_comb begin
      sclk_d = sclk_in;
      rx_d = rx_q;
      cnt_d = cnt_q;
      tx_d = tx_q;
      miso_d = miso_q;
      wr_d = 1'b0;
      if (ss_n_in) begin
         cnt_d = 5'h00;
         miso_d = 1'b0;
      end else if (rise && cnt_q < 5'(ocd_pkg::FRAME_BITS)) begin
         rx_d = {rx_q[14:0], mosi_in};
         cnt_d = cnt_q + 5'h01;
         // A write needs the read/write bit low; a read frame only shifts.
         // After fifteen shifts that bit sits just above the seven data bits.
         if (cnt_q == 5'(ocd_pkg::FRAME_BITS - 1) && !rx_q[HEAD_BITS_ADDR_MSB]) begin
            wr_d = 1'b1;
         end
      end else if (fall && cnt_q == 5'(ocd_pkg::HEAD_BITS) && rx_q[0]) begin
         miso_d = rdata_in[7];
         tx_d = {rdata_in[6:0], 1'b0};
      end else if (fall && cnt_q > 5'(ocd_pkg::HEAD_BITS)) begin
         miso_d = tx_q[7];
         tx_d = {tx_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sclk_q <= 1'b0;
         rx_q <= 16'h0000;
         cnt_q <= 5'h00;
         tx_q <= 8'h00;
         miso_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         sclk_q <= sclk_d;
         rx_q <= rx_d;
         cnt_q <= cnt_d;
         tx_q <= tx_d;
         miso_q <= miso_d;
         wr_q <= wr_d;
      end
   end
endmodule

/* File: src/ocd_top.sv */
`timescale 1ns/1ns
// How it works
// - Receiver overcurrent sets status bit 7.
// - Headphone overcurrent sets sticky status bit 6.
// - Speaker overcurrent sets sticky status bit 5.
// - Headphone protection armed only by bit 0.
// - Period code 0 off, else 144/288/4608.
// - Pulse high for N times scale cycles.
// - Scale bit selects multiplier one or eight.
// - Tuning resets to period 2, N 5, scale 0.
// - Reserved locations read zero, writes ignored.
// - Insertion auto-config forces long period, scale eight.
module ocd_top #(
   parameter int PERIOD_SHORT_CYC = ocd_pkg::CYC_PERIOD_SHORT,
   parameter int PERIOD_MID_CYC = ocd_pkg::CYC_PERIOD_MID,
   parameter int PERIOD_LONG_CYC = ocd_pkg::CYC_PERIOD_LONG
) (
   // Clock and reset.
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   // Serial control port.
   input wire logic SCLK_IN,
   input wire logic SS_N_IN,
   input wire logic MOSI_IN,
   output logic MISO_OUT,
   // Analog sense inputs.
   input wire logic RCV_OC_IN,
   input wire logic HP_OC_IN,
   input wire logic SPK_OC_IN,
   input wire logic MIC_INSERT_IN,
   input wire logic LOW_FREQ_OSC_CLOCK_IN,
   // Driver controls.
   output logic HP_OC_PROTECT_EN_OUT,
   output logic HP_OC_SHUTDOWN_OUT,
   output logic HP_DETECT_PULSE_OUT
);
   // ==========================================================
   // Register port.
   logic [6:0] addr;
   logic wr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   ocd_serial_port u_port (
      .clk_in(MCLK_IN),
      .rst_n_in(RST_N_IN),
      .sclk_in(SCLK_IN),
      .ss_n_in(SS_N_IN),
      .mosi_in(MOSI_IN),
      .miso_out(MISO_OUT),
      .addr_out(addr),
      .wr_out(wr),
      .wdata_out(wdata),
      .rdata_in(rdata)
   );

   // ==========================================================
   // Registers and flags.
   logic [7:0] oc_q, oc_d;
   logic [7:0] prot_q, prot_d;
   logic [7:0] tune_q, tune_d;
   logic ins_q, ins_d;
   logic shut_q, shut_d;

   always_comb begin
      // Sticky flags: once set only reset clears them.
      oc_d = oc_q;
      if (RCV_OC_IN) oc_d[ocd_pkg::OC_RCV_BIT] = 1'b1;
      if (HP_OC_IN) oc_d[ocd_pkg::OC_HP_BIT] = 1'b1;
      if (SPK_OC_IN) oc_d[ocd_pkg::OC_SPK_BIT] = 1'b1;
      prot_d = prot_q;
      tune_d = tune_q;
      ins_d = MIC_INSERT_IN;
      if (wr && addr == ocd_pkg::ADDR_HP_PROT) begin
         // Only the enable bit is writable; the rest stays zero.
         prot_d = ocd_pkg::RSVD_VALUE;
         prot_d[ocd_pkg::PROT_EN_BIT] = wdata[ocd_pkg::PROT_EN_BIT];
      end
      if (wr && addr == ocd_pkg::ADDR_TUNE_ONE) begin
         tune_d = wdata;
      end
      // Insertion wins over a same-cycle write, so the forced setup is never lost.
      if (MIC_INSERT_IN && !ins_q && !tune_q[ocd_pkg::AUTO_BIT]) begin
         tune_d[ocd_pkg::PERIOD_MSB:ocd_pkg::PERIOD_LSB] = ocd_pkg::PERIOD_LONG;
         tune_d[ocd_pkg::SCALE_BIT] = 1'b1;
      end
      shut_d = prot_q[ocd_pkg::PROT_EN_BIT] & oc_q[ocd_pkg::OC_HP_BIT];
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         oc_q <= 8'h00;
         prot_q <= ocd_pkg::RST_HP_PROT;
         tune_q <= ocd_pkg::RST_TUNE_ONE;
         ins_q <= 1'b0;
         shut_q <= 1'b0;
      end else begin
         oc_q <= oc_d;
         prot_q <= prot_d;
         tune_q <= tune_d;
         ins_q <= ins_d;
         shut_q <= shut_d;
      end
   end

   assign HP_OC_PROTECT_EN_OUT = prot_q[ocd_pkg::PROT_EN_BIT];
   assign HP_OC_SHUTDOWN_OUT = shut_q;

   always_comb begin
      case (addr)
         ocd_pkg::ADDR_OC_STATUS: rdata = oc_q;
         ocd_pkg::ADDR_HP_PROT: rdata = prot_q;
         ocd_pkg::ADDR_TUNE_ONE: rdata = tune_q;
         default: rdata = ocd_pkg::RSVD_VALUE;
      endcase
   end

   // ==========================================================
   // Detection pulse generator.
   // The oscillator clock is sampled; it must run well below the main clock.
   logic lf_q, lf_d;
   logic [12:0] cnt_q, cnt_d;
   logic pulse_q, pulse_d;
   ocd_pkg::ocd_pulse_state_type st_q, st_d;
   logic [12:0] period_cyc;
   logic [12:0] high_cyc;
   logic [1:0] period_code;
   logic lf_edge;
   logic run;

   assign period_code = tune_q[ocd_pkg::PERIOD_MSB:ocd_pkg::PERIOD_LSB];
   assign lf_edge = LOW_FREQ_OSC_CLOCK_IN & ~lf_q;
   assign run = MIC_INSERT_IN && period_code != ocd_pkg::PERIOD_OFF;

   always_comb begin
      case (period_code)
         ocd_pkg::PERIOD_SHORT: period_cyc = 13'(PERIOD_SHORT_CYC);
         ocd_pkg::PERIOD_MID: period_cyc = 13'(PERIOD_MID_CYC);
         ocd_pkg::PERIOD_LONG: period_cyc = 13'(PERIOD_LONG_CYC);
         default: period_cyc = 13'h0000;
      endcase
      // Code 0 is reserved; it yields no high time at all.
      if (tune_q[ocd_pkg::SCALE_BIT]) begin
         high_cyc = 13'(tune_q[ocd_pkg::HIGH_MSB:ocd_pkg::HIGH_LSB]) * 13'(ocd_pkg::SCALE_HIGH);
      end else begin
         high_cyc = 13'(tune_q[ocd_pkg::HIGH_MSB:ocd_pkg::HIGH_LSB]) * 13'(ocd_pkg::SCALE_LOW);
      end
   end

   always_comb begin
      lf_d = LOW_FREQ_OSC_CLOCK_IN;
      st_d = st_q;
      cnt_d = cnt_q;
      if (!run) begin
         st_d = ocd_pkg::PG_IDLE;
         cnt_d = 13'h0000;
      end else if (lf_edge) begin
         case (st_q)
            ocd_pkg::PG_IDLE: begin
               cnt_d = 13'h0001;
               st_d = (high_cyc != 13'h0000) ? ocd_pkg::PG_HIGH : ocd_pkg::PG_LOW;
            end
            ocd_pkg::PG_HIGH: begin
               cnt_d = cnt_q + 13'h0001;
               if (cnt_q >= high_cyc) st_d = ocd_pkg::PG_LOW;
            end
            ocd_pkg::PG_LOW: begin
               cnt_d = cnt_q + 13'h0001;
               if (cnt_q >= period_cyc) begin
                  cnt_d = 13'h0001;
                  st_d = (high_cyc != 13'h0000) ? ocd_pkg::PG_HIGH : ocd_pkg::PG_LOW;
               end
            end
            default: st_d = ocd_pkg::PG_IDLE;
         endcase
      end
      pulse_d = (st_d == ocd_pkg::PG_HIGH);
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         lf_q <= 1'b0;
         st_q <= ocd_pkg::PG_IDLE;
         cnt_q <= 13'h0000;
         pulse_q <= 1'b0;
      end else begin
         lf_q <= lf_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         pulse_q <= pulse_d;
      end
   end

   assign HP_DETECT_PULSE_OUT = pulse_q;
endmodule

/* File: tb/ocd_load_model.sv */
`timescale 1ns/1ns
// ==========================================
// Driver loads: sense lines follow commanded shorts, slow oscillator runs free.
module ocd_load_model #(
   parameter int LF_HALF_NS = 400
) (
   // Commanded faults, receiver then headphone then speaker.
   input wire logic [2:0] short_in,
   // Sense lines and oscillator.
   output logic rcv_oc_out,
   output logic hp_oc_out,
   output logic spk_oc_out,
   output logic lf_clk_out
);
   // The analog delay keeps sense changes away from the sampling edge.
   assign #30 {rcv_oc_out, hp_oc_out, spk_oc_out} = short_in;
   initial begin
      lf_clk_out = 1'b0;
      forever #(LF_HALF_NS) lf_clk_out = ~lf_clk_out;
   end
endmodule

/* File: tb/ocd_props.sv */
`timescale 1ns/1ns
// ==========================================
// Port checks for fault shutdown and the detection pulse.
module ocd_props (
   // Clock and reset.
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   // Watched pins.
   input wire logic SS_N_IN,
   input wire logic HP_OC_IN,
   input wire logic MIC_INSERT_IN,
   input wire logic LOW_FREQ_OSC_CLOCK_IN,
   input wire logic HP_OC_PROTECT_EN_OUT,
   input wire logic HP_OC_SHUTDOWN_OUT,
   input wire logic HP_DETECT_PULSE_OUT
);
   logic [3:0] lf_age_q;
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // Saturating age of the last slow edge, so it never wraps into a false pass.
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         lf_age_q <= 4'hf;
      end else if ($rose(LOW_FREQ_OSC_CLOCK_IN)) begin
         lf_age_q <= 4'h0;
      end else if (lf_age_q != 4'hf) begin
         lf_age_q <= lf_age_q + 4'h1;
      end
   end
   a_disarmed_no_shut: assert property (
      !HP_OC_PROTECT_EN_OUT [*2] |-> !HP_OC_SHUTDOWN_OUT)
      else $error("shutdown while protection off");
   a_shut_holds: assert property (
      HP_OC_SHUTDOWN_OUT ##1 HP_OC_PROTECT_EN_OUT [*2] |-> HP_OC_SHUTDOWN_OUT)
      else $error("shutdown dropped while armed");
   a_hp_fault_shut: assert property (
      HP_OC_IN ##1 HP_OC_PROTECT_EN_OUT [*4] |-> HP_OC_SHUTDOWN_OUT)
      else $error("headphone fault missed");
   a_arm_by_write: assert property (
      $rose(HP_OC_PROTECT_EN_OUT) |-> !$past(SS_N_IN, 2))
      else $error("protection armed outside a frame");
   a_reset_quiet: assert property (
      $rose(RST_N_IN) |-> !HP_OC_PROTECT_EN_OUT && !HP_OC_SHUTDOWN_OUT && !HP_DETECT_PULSE_OUT)
      else $error("outputs active after reset");
   a_pulse_needs_mic: assert property (
      !MIC_INSERT_IN [*3] |-> !HP_DETECT_PULSE_OUT)
      else $error("pulse without insertion");
   a_pulse_on_lf: assert property (
      $rose(HP_DETECT_PULSE_OUT) |-> lf_age_q <= 4'h5)
      else $error("pulse rose away from a slow edge");
   a_pulse_no_glitch: assert property (
      $rose(HP_DETECT_PULSE_OUT) && SS_N_IN ##1 MIC_INSERT_IN [*3] |-> HP_DETECT_PULSE_OUT)
      else $error("pulse shorter than a slow cycle");
endmodule

/* File: tb/ocd_top_test.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
bind ocd_top ocd_props chk_u (.*);
// ==========================================
// Serial register access, fault flags and detection pulse timing.
module ocd_top_test;
   localparam int PER[4] = '{0, 6, 12, 40};
   localparam int LF = 8;
   localparam logic [6:0] ST = ocd_pkg::ADDR_OC_STATUS;
   localparam logic [6:0] PR = ocd_pkg::ADDR_HP_PROT;
   localparam logic [6:0] TU = ocd_pkg::ADDR_TUNE_ONE;
   logic MCLK_IN = 1'b0;
   logic RST_N_IN = 1'b0;
   logic SCLK_IN = 1'b0;
   logic SS_N_IN = 1'b1;
   logic MOSI_IN = 1'b0;
   logic MIC_INSERT_IN = 1'b0;
   logic [2:0] shorts = 3'h0;
   logic MISO_OUT, RCV_OC_IN, HP_OC_IN, SPK_OC_IN, LOW_FREQ_OSC_CLOCK_IN;
   logic HP_OC_PROTECT_EN_OUT, HP_OC_SHUTDOWN_OUT, HP_DETECT_PULSE_OUT;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int hi, per;
   ocd_top #(.PERIOD_SHORT_CYC(PER[1]), .PERIOD_MID_CYC(PER[2]), .PERIOD_LONG_CYC(PER[3]))
      dut_u (.*);
   ocd_load_model #(.LF_HALF_NS(LF * 50)) load_u (.short_in(shorts), .rcv_oc_out(RCV_OC_IN),
      .hp_oc_out(HP_OC_IN), .spk_oc_out(SPK_OC_IN), .lf_clk_out(LOW_FREQ_OSC_CLOCK_IN));
   initial begin
      forever #50 MCLK_IN = ~MCLK_IN;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge MCLK_IN) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         final_report();
      end
   end
   // SCLK phases last three cycles, above the one the port needs.
   task automatic xfer(input logic [15:0] f, output logic [7:0] q);
      SS_N_IN = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         MOSI_IN = f[i];
         repeat (3) @(negedge MCLK_IN);
         if (i < 8) q[i] = MISO_OUT;
         SCLK_IN = 1'b1;
         repeat (3) @(negedge MCLK_IN);
         SCLK_IN = 1'b0;
      end
      repeat (6) @(negedge MCLK_IN);
      SS_N_IN = 1'b1;
      repeat (3) @(negedge MCLK_IN);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer({a, 1'b0, d}, q);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string n);
      logic [7:0] q;
      xfer({a, 1'b1, 8'h00}, q);
      `CHK(n, e, q)
   endtask
   task automatic hit(input logic [2:0] m);
      shorts = m;
      repeat (4) @(negedge MCLK_IN);
      shorts = 3'h0;
      repeat (4) @(negedge MCLK_IN);
   endtask
   task automatic count(input logic v, output int n);
      n = 0;
      while (HP_DETECT_PULSE_OUT !== v && n < 800) begin
         @(negedge MCLK_IN);
         n++;
      end
   endtask
   // A pulse already high after a write is waited out, so the first whole pulse from its rise is measured.
   task automatic meas();
      int n, lo;
      count(1'b0, n);
      count(1'b1, n);
      count(1'b0, hi);
      count(1'b1, lo);
      per = (n < 800) ? hi + lo : 0;
   endtask
   initial begin
      logic [7:0] cfg[5] = '{8'h95, 8'h49, 8'h87, 8'hc7, 8'h15};
      repeat (16) @(negedge MCLK_IN);
      RST_N_IN = 1'b1;
      @(negedge MCLK_IN);
      rd_chk(ST, 8'h00, "status reset");
      rd_chk(PR, 8'h00, "protect reset");
      rd_chk(TU, {ocd_pkg::PERIOD_MID, 4'h5, 2'h0}, "tuning reset");
      rd_chk(ocd_pkg::ADDR_RSVD_A, 8'h00, "reserved a");
      rd_chk(7'h7f, 8'h00, "unmapped");
      $display("test reset values done");
      hit(3'h4);
      rd_chk(ST, 8'h80, "receiver flag");
      hit(3'h2);
      rd_chk(ST, 8'hc0, "headphone flag");
      `CHK("shutdown disarmed", 1'b0, HP_OC_SHUTDOWN_OUT)
      hit(3'h1);
      rd_chk(ST, 8'he0, "speaker flag");
      wr(PR, 8'hff);
      rd_chk(PR, 8'h01, "protect bits");
      `CHK("protect out", 1'b1, HP_OC_PROTECT_EN_OUT)
      `CHK("shutdown armed", 1'b1, HP_OC_SHUTDOWN_OUT)
      hit(3'h2);
      wr(ocd_pkg::ADDR_RSVD_B, 8'hff);
      wr(ST, 8'h00);
      rd_chk(ocd_pkg::ADDR_RSVD_B, 8'h00, "reserved b");
      rd_chk(ST, 8'he0, "status kept");
      $display("test overcurrent done");
      wr(TU, cfg[0]);
      MIC_INSERT_IN = 1'b1;
      foreach (cfg[i]) begin
         wr(TU, cfg[i]);
         meas();
         `CHK("pulse high", (cfg[i][7:6] == 2'h0) ? 0 : cfg[i][5:2] * (cfg[i][1] ? 8 : 1) * LF, hi)
         `CHK("pulse period", PER[cfg[i][7:6]] * LF, per)
      end
      $display("test pulse timing done");
      MIC_INSERT_IN = 1'b0;
      wr(TU, 8'h84);
      MIC_INSERT_IN = 1'b1;
      rd_chk(TU, 8'hc6, "auto config");
      meas();
      `CHK("auto high", 8 * LF, hi)
      `CHK("auto period", PER[3] * LF, per)
      MIC_INSERT_IN = 1'b0;
      wr(TU, 8'h85);
      MIC_INSERT_IN = 1'b1;
      rd_chk(TU, 8'h85, "auto off");
      $display("test auto config done");
      MIC_INSERT_IN = 1'b0;
      RST_N_IN = 1'b0;
      repeat (16) @(negedge MCLK_IN);
      RST_N_IN = 1'b1;
      @(negedge MCLK_IN);
      rd_chk(ST, 8'h00, "status cleared");
      rd_chk(TU, 8'h94, "tuning restored");
      $display("test second reset done");
      final_report();
   end
endmodule
